// ### design/lbarb_top.sv
// Local bus arbiter with halt, shutdown and interrupt-acknowledge handling.
// Assumes synchronous inputs; op_done marks the end of a granted operation.
`timescale 1ns/1ns
// Functional notes
// - Locked transfers get top bus priority.
// - Second byte of odd word ranks second.
// - Coprocessor second or third cycle ranks third.
// - Bus-hold request ranks fourth.
// - Coprocessor operand ranks fifth, execution data sixth.
// - Prefetch has lowest priority.
// - Prefetch suppressed two clocks before an execution data transfer.
// - Halt on halt instruction, shutdown on multiple exceptions; bus op.
// - Halt/shutdown op drives both status low, code low, memio high.
// - Address bit one high for halt, low for shutdown.
// - Hold and coprocessor requests still served while halted.
// - Coprocessor overrun in shutdown blocks coprocessor service.
// - Non-maskable interrupt or reset leaves halt or shutdown.
// - Enabled maskable irq or overrun leaves halt only.
// - Address leaves high impedance in second command state.
// - Lock asserted through both acknowledge cycles.
// - Hold during write: finish write, one idle, then acknowledge.
// - Three idle clocks between the acknowledge operations.
// - No hold grant before second acknowledge ends.
module lbarb_top
	import lbarb_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic lock_req,
	input  wire logic odd_second_req,
	input  wire logic copro_cont_req,
	input  wire logic bus_hold_req,
	input  wire logic copro_operand_req,
	input  wire logic exec_req,
	input  wire logic exec_req_soon,
	input  wire logic fetch_req,
	input  wire logic irq_ack_req,
	input  wire logic op_write,
	input  wire logic op_done,
	input  wire logic t_c_tick,
	input  wire logic halt_instruction,
	input  wire logic multi_exception,
	input  wire logic nmi,
	input  wire logic maskable_irq,
	input  wire logic irq_enabled,
	input  wire logic copro_overrun,
	output logic      grant_lock,
	output logic      grant_odd_second,
	output logic      grant_copro_cont,
	output logic      bus_hold_ack,
	output logic      grant_copro,
	output logic      grant_exec,
	output logic      grant_fetch,
	output logic      irq_ack_cycle,
	output logic      irq_ack_second,
	output logic      bus_status_1_n,
	output logic      bus_status_0_n,
	output logic      code_or_ack_n,
	output logic      mem_or_io,
	output logic      addr_bit_one,
	output logic      addr_oe_n,
	output logic      lock_n,
	output logic      halted,
	output logic      shut_down
);
	typedef struct packed {
		lbarb_bus_t bus;
		lbarb_cpu_t cpu;
		lbarb_vec_t grant;
		logic       ack_phase;
		logic       ack_active;
		logic       copro_block;
		logic       last_write;
		logic [1:0] tc_cnt;
		logic       s1_n;
		logic       s0_n;
		logic       cod_n;
		logic       mio;
		logic       a1;
		logic       aoe_n;
		logic       lck_n;
		logic       hold_ack;
	} lbarb_state_t;
	lbarb_state_t st;
	lbarb_state_t next_st;
	lbarb_req_if  rq ();
	logic         gap_load;
	logic [2:0]   gap_value;
	logic         gap_busy;
	logic         fetch_ok;
	logic         copro_ok;
	logic         hold_ok;
	logic         cpu_run;
	logic         ack_go;

	lbarb_pick u_pick (
		.rq (rq.picker)
	);
	lbarb_gap #(
		.W (3)
	) u_gap (
		.clk   (clk),
		.srst  (srst),
		.load  (gap_load),
		.value (gap_value),
		.busy  (gap_busy)
	);

	assign cpu_run  = (st.cpu == LBARB_RUN);
	// Second acknowledge op follows without a new request
	assign ack_go   = irq_ack_req | st.ack_phase;
	assign fetch_ok = cpu_run & ~exec_req_soon & ~exec_req;
	assign copro_ok = ~st.copro_block;
	assign hold_ok  = ~st.ack_active;
	always_comb
	begin
		rq.req = '0;
		rq.req[`LBARB_IDX_LOCK]    = cpu_run & (lock_req | ack_go);
		rq.req[`LBARB_IDX_ODD2]    = cpu_run & odd_second_req;
		rq.req[`LBARB_IDX_COPRO23] = copro_cont_req & copro_ok;
		rq.req[`LBARB_IDX_HOLD]    = bus_hold_req & hold_ok;
		rq.req[`LBARB_IDX_COPRO]   = copro_operand_req & copro_ok;
		rq.req[`LBARB_IDX_EXEC]    = cpu_run & exec_req;
		rq.req[`LBARB_IDX_FETCH]   = fetch_req & fetch_ok;
	end

	always_comb
	begin
		next_st   = st;
		gap_load  = 1'b0;
		gap_value = 3'h0;
		// Leaving halt and shutdown
		if (st.cpu != LBARB_RUN && nmi)
			next_st.cpu = LBARB_RUN;
		else if (st.cpu == LBARB_HALTED &&
			((maskable_irq && irq_enabled) || copro_overrun))
			next_st.cpu = LBARB_RUN;
		if (st.cpu == LBARB_SHUTDOWN && copro_overrun)
			next_st.copro_block = 1'b1;
		case (st.bus)
			LBARB_IDLE:
			begin
				next_st.s1_n  = 1'b1;
				next_st.s0_n  = 1'b1;
				next_st.lck_n = 1'b1;
				if (!gap_busy && cpu_run && !st.ack_active &&
					(halt_instruction || multi_exception))
				begin
					// Halt or shutdown shown as a bus status code
					next_st.cpu   = halt_instruction ? LBARB_HALTED
						: LBARB_SHUTDOWN;
					next_st.s1_n  = 1'b0;
					next_st.s0_n  = 1'b0;
					next_st.cod_n = 1'b0;
					next_st.mio   = 1'b1;
					next_st.a1    = halt_instruction;
				end
				else if (!gap_busy && rq.req != '0)
				begin
					// One grant per boundary, held until done
					next_st.grant = rq.grant;
					next_st.last_write = op_write;
					if (rq.grant[`LBARB_IDX_HOLD])
					begin
						next_st.bus      = LBARB_HOLDST;
						next_st.hold_ack = 1'b1;
						next_st.aoe_n    = 1'b1;
					end
					else
					begin
						next_st.bus = LBARB_BUSY;
						next_st.s1_n  = op_write;
						next_st.s0_n  = ~op_write;
						next_st.mio   = ~ack_go;
						next_st.cod_n = ~ack_go & rq.grant[`LBARB_IDX_FETCH];
						next_st.tc_cnt = 2'h0;
						if (ack_go && rq.grant[`LBARB_IDX_LOCK])
						begin
							next_st.ack_active = 1'b1;
							next_st.lck_n = 1'b0;
							if (st.ack_phase)
								next_st.aoe_n = 1'b1;
						end
						else
							next_st.lck_n = ~rq.grant[`LBARB_IDX_LOCK];
					end
				end
			end
			LBARB_BUSY:
			begin
				next_st.s1_n = 1'b1;
				next_st.s0_n = 1'b1;
				if (t_c_tick && st.tc_cnt != 2'h3)
					next_st.tc_cnt = st.tc_cnt + 2'h1;
				if (st.ack_active && st.ack_phase && t_c_tick &&
					st.tc_cnt == 2'(`LBARB_ACK_T_C_EXTRA - 1))
					next_st.aoe_n = 1'b0;
				if (op_done)
				begin
					next_st.grant = '0;
					next_st.lck_n = 1'b1;
					if (st.ack_active && !st.ack_phase)
					begin
						next_st.ack_phase = 1'b1;
						next_st.bus = LBARB_ACKGAP;
						gap_load  = 1'b1;
						// Gap exit and grant edge give two of the idle clocks
						gap_value = 3'(`LBARB_ACK_IDLE - 2);
					end
					else
					begin
						if (st.ack_active)
						begin
							next_st.ack_active = 1'b0;
							next_st.ack_phase  = 1'b0;
							next_st.aoe_n      = 1'b0;
						end
						next_st.bus = LBARB_IDLE;
						if (st.last_write && bus_hold_req)
						begin
							next_st.bus = LBARB_GAP;
							gap_load  = 1'b1;
							gap_value = 3'(`LBARB_HOLD_IDLE - 1);
						end
					end
				end
			end
			LBARB_GAP:
			begin
				if (!gap_busy && bus_hold_req && hold_ok)
				begin
					// One idle state after the write, then hold
					next_st.bus      = LBARB_HOLDST;
					next_st.hold_ack = 1'b1;
					next_st.aoe_n    = 1'b1;
					next_st.grant    = '0;
					next_st.grant[`LBARB_IDX_HOLD] = 1'b1;
				end
				else if (!gap_busy)
					next_st.bus = LBARB_IDLE;
			end
			LBARB_ACKGAP:
			begin
				if (!gap_busy)
					next_st.bus = LBARB_IDLE;
			end
			LBARB_HOLDST:
			begin
				if (!bus_hold_req)
				begin
					next_st.hold_ack = 1'b0;
					next_st.aoe_n    = 1'b0;
					next_st.grant    = '0;
					next_st.bus      = LBARB_IDLE;
				end
			end
			default:
			begin
				next_st.bus = LBARB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// Reset also leaves halt or shutdown
			st          <= '0;
			st.bus      <= LBARB_IDLE;
			st.cpu      <= LBARB_RUN;
			st.s1_n     <= 1'b1;
			st.s0_n     <= 1'b1;
			st.cod_n    <= 1'b1;
			st.lck_n    <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign grant_lock       = st.grant[`LBARB_IDX_LOCK];
	assign grant_odd_second = st.grant[`LBARB_IDX_ODD2];
	assign grant_copro_cont = st.grant[`LBARB_IDX_COPRO23];
	assign bus_hold_ack     = st.hold_ack;
	assign grant_copro      = st.grant[`LBARB_IDX_COPRO];
	assign grant_exec       = st.grant[`LBARB_IDX_EXEC];
	assign grant_fetch      = st.grant[`LBARB_IDX_FETCH];
	assign irq_ack_cycle    = st.ack_active;
	assign irq_ack_second   = st.ack_phase;
	assign bus_status_1_n   = st.s1_n;
	assign bus_status_0_n   = st.s0_n;
	assign code_or_ack_n    = st.cod_n;
	assign mem_or_io        = st.mio;
	assign addr_bit_one     = st.a1;
	assign addr_oe_n        = st.aoe_n;
	assign lock_n           = st.lck_n;
	assign halted           = (st.cpu == LBARB_HALTED);
	assign shut_down        = (st.cpu == LBARB_SHUTDOWN);
endmodule

// ### design/lbarb_map.svh
// Offsets-free constants for the local bus arbiter: encodings and counts.
// Assumes inclusion by bare name from the arbiter package and modules.
`ifndef LBARB_MAP_SVH
`define LBARB_MAP_SVH
`define LBARB_NREQ          7
`define LBARB_IDX_LOCK      0
`define LBARB_IDX_ODD2      1
`define LBARB_IDX_COPRO23   2
`define LBARB_IDX_HOLD      3
`define LBARB_IDX_COPRO     4
`define LBARB_IDX_EXEC      5
`define LBARB_IDX_FETCH     6
`define LBARB_PREFETCH_GAP  2
`define LBARB_ACK_IDLE      3
`define LBARB_HOLD_IDLE     1
`define LBARB_ACK_T_C_EXTRA 2
`endif

// ### design/lbarb_pkg.sv
// Types shared by the local bus arbiter modules.
// Assumes lbarb_map.svh is on the include path.
`include "lbarb_map.svh"
package lbarb_pkg;
	typedef enum logic [2:0] {
		LBARB_IDLE,
		LBARB_BUSY,
		LBARB_GAP,
		LBARB_HOLDST,
		LBARB_ACKGAP
	} lbarb_bus_t;
	typedef enum logic [1:0] {
		LBARB_RUN,
		LBARB_HALTED,
		LBARB_SHUTDOWN
	} lbarb_cpu_t;
	typedef logic [`LBARB_NREQ-1:0] lbarb_vec_t;
endpackage

// ### design/lbarb_req_if.sv
// Request and grant vectors between the arbiter core and its priority picker.
// Assumes both ends share clk domain of the top module.
`timescale 1ns/1ns
interface lbarb_req_if;
	import lbarb_pkg::*;
	lbarb_vec_t req;
	lbarb_vec_t grant;
	modport core   (output req, input grant);
	modport picker (input req, output grant);
endinterface

// ### design/lbarb_pick.sv
// Fixed priority picker: lowest index wins.
// Assumes request vector is ordered highest priority first.
`timescale 1ns/1ns
module lbarb_pick
	import lbarb_pkg::*;
(
	lbarb_req_if.picker rq
);
	genvar i;
	generate
		for (i = 0; i < `LBARB_NREQ; i++)
		begin : g_pick
			if (i == 0)
			begin : g_top
				assign rq.grant[i] = rq.req[i];
			end
			else
			begin : g_low
				// Wins only if no higher-ranked request is up
				assign rq.grant[i] = rq.req[i] & ~(|rq.req[i-1:0]);
			end
		end
	endgenerate
endmodule

// ### design/lbarb_gap.sv
// Down counter holding the bus idle for a set number of clocks.
// Assumes load and count are synchronous to clk.
`timescale 1ns/1ns
module lbarb_gap
	import lbarb_pkg::*;
#(
	parameter int W = 3
)
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              busy
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} lbarb_gap_t;
	lbarb_gap_t st;
	lbarb_gap_t next_st;
	always_comb
	begin
		next_st = st;
		if (load)
			next_st.cnt = value;
		else if (st.cnt != '0)
			next_st.cnt = st.cnt - 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end
	assign busy = (st.cnt != '0);
endmodule

// ### verification/lbarb_partner.sv
// Far side model: bus controller ending each granted operation.
// Assumes busy is high while the arbiter holds an operation grant.
`timescale 1ns/1ns
module lbarb_partner
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic busy,
	input  wire logic slow,
	output logic      op_done,
	output logic      t_c_tick
);
	logic [2:0] cnt;
	// Halt ops are not busy, so they get no ready
	always_ff @(posedge clk)
	begin
		if (srst || !busy || op_done)
			cnt <= 3'h0;
		else
			cnt <= cnt + 3'h1;
		// Slow adds wait states and command states
		op_done <= !srst && busy && !op_done && cnt == (slow ? 3'h3 : 3'h1);
		t_c_tick <= !srst && busy && !op_done;
	end
endmodule

// ### verification/lbarb_top_asserts.sv
// Port checker for the local bus arbiter top.
// Assumes binding into lbarb_top; srst resets synchronously.
`timescale 1ns/1ns
module lbarb_top_asserts
(
	input wire logic clk,
	input wire logic srst,
	input wire logic lock_req,
	input wire logic odd_second_req,
	input wire logic copro_cont_req,
	input wire logic bus_hold_req,
	input wire logic copro_operand_req,
	input wire logic exec_req,
	input wire logic exec_req_soon,
	input wire logic op_done,
	input wire logic grant_lock,
	input wire logic grant_odd_second,
	input wire logic grant_copro_cont,
	input wire logic bus_hold_ack,
	input wire logic grant_copro,
	input wire logic grant_exec,
	input wire logic grant_fetch,
	input wire logic irq_ack_cycle,
	input wire logic bus_status_1_n,
	input wire logic bus_status_0_n,
	input wire logic code_or_ack_n,
	input wire logic mem_or_io,
	input wire logic addr_bit_one,
	input wire logic lock_n,
	input wire logic halted,
	input wire logic shut_down
);
	wire logic [5:0] gr = {grant_lock, grant_odd_second, grant_copro_cont,
		grant_copro, grant_exec, grant_fetch};
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	chk_one_grant: assert property ($onehot0({gr, bus_hold_ack}))
		else $error("more than one grant");
	chk_grant_held: assert property (!$past(srst) &&
		|$past(gr) && !(|gr) |-> $past(op_done)) else $error("grant cut");
	chk_halt_code: assert property ($rose(halted) |->
		!bus_status_1_n && !bus_status_0_n && !code_or_ack_n && mem_or_io
		&& addr_bit_one) else $error("halt code wrong");
	chk_shut_code: assert property ($rose(shut_down) |->
		!bus_status_1_n && !bus_status_0_n && !code_or_ack_n && mem_or_io
		&& !addr_bit_one) else $error("shutdown code wrong");
	chk_fetch_gap: assert property ($rose(grant_fetch) |->
		!$past(exec_req_soon) && !$past(exec_req)) else $error("early fetch");
	chk_exec_rank: assert property ($rose(grant_exec) |->
		!$past(lock_req | odd_second_req | copro_cont_req | bus_hold_req
		| copro_operand_req)) else $error("exec out of rank");
	chk_hold_rank: assert property ($rose(bus_hold_ack) |->
		!$past(lock_req | odd_second_req | copro_cont_req) && !$past(|gr))
		else $error("hold out of rank");
	chk_ack_nohold: assert property (irq_ack_cycle |->
		!$rose(bus_hold_ack)) else $error("hold inside ack");
	chk_ack_lock: assert property ($rose(irq_ack_cycle) |->
		##[0:8] !lock_n) else $error("ack not locked");
endmodule
bind lbarb_top lbarb_top_asserts lbarb_top_asserts_i (.*);

// ### verification/lbarb_top_tb.sv
// Self-checking bench for the local bus arbiter top.
// Assumes the partner model answers every granted operation.
`timescale 1ns/1ns
module lbarb_top_tb;
	import lbarb_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic lock_req, odd_second_req, copro_cont_req, bus_hold_req;
	logic copro_operand_req, exec_req, exec_req_soon, fetch_req;
	logic irq_ack_req, op_write, halt_instruction, multi_exception;
	logic nmi, maskable_irq, irq_enabled, copro_overrun, slow_pick;
	logic grant_lock, grant_odd_second, grant_copro_cont, bus_hold_ack;
	logic grant_copro, grant_exec, grant_fetch, irq_ack_cycle;
	logic irq_ack_second, bus_status_1_n, bus_status_0_n, code_or_ack_n;
	logic mem_or_io, addr_bit_one, addr_oe_n, lock_n, halted, shut_down;
	logic op_done, t_c_tick, stop, blk;
	logic [1:0] lat;
	int fails, cmp_count, k, n_h, n_f, n_l, n_g, n_d;
	wire logic [6:0] ov = {grant_lock, grant_odd_second, grant_copro_cont,
		bus_hold_ack, grant_copro, grant_exec, grant_fetch};
	wire logic [6:0] st = {halted, shut_down, bus_status_1_n, bus_status_0_n,
		code_or_ack_n, mem_or_io, addr_bit_one};
	wire logic busy = (|ov[6:4]) | (|ov[2:0]);
	wire logic slow = slow_pick | irq_ack_cycle;
	lbarb_top lbarb_top_i (.*);
	lbarb_partner lbarb_partner_i (.*);
	always #25 clk = ~clk;
	// Address latch: cycle type captured in the status state
	always @(posedge clk)
		if (!bus_status_1_n || !bus_status_0_n)
			lat <= {code_or_ack_n, mem_or_io};
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d of %0d compares", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [6:0] pick(input logic [6:0] r, input logic s);
		logic [6:0] v;
		v = r;
		if (s || r[1])
			v[0] = 1'b0;
		if (stop)
			v = v & (blk ? 7'h08 : 7'h0C);
		for (int i = 6; i >= 0; i--)
			if (v[i])
				return 7'h01 << i;
		return 7'h00;
	endfunction
	task automatic trial(input logic [6:0] r, input logic s);
		@(posedge clk);
		{lock_req, odd_second_req, copro_cont_req, bus_hold_req,
			copro_operand_req, exec_req, fetch_req} <= r;
		exec_req_soon <= s;
		op_write <= 1'($urandom);
		slow_pick <= 1'($urandom);
		for (k = 0; k < 8 && ov == 7'h00; k++)
			@(negedge clk);
		check("grant", ov, pick(r, s));
		@(posedge clk);
		{lock_req, odd_second_req, copro_cont_req, bus_hold_req,
			copro_operand_req, exec_req, fetch_req, exec_req_soon} <= 8'h00;
		for (k = 0; k < 20 && ov !== 7'h00; k++)
			@(negedge clk);
	endtask
	task automatic ev(input logic [4:0] m);
		@(posedge clk);
		{halt_instruction, multi_exception, nmi, maskable_irq,
			copro_overrun} <= m;
		@(posedge clk);
		{halt_instruction, multi_exception, nmi, maskable_irq,
			copro_overrun} <= 5'h00;
		@(negedge clk);
	endtask
	initial
	begin
		#1000000;
		fails++;
		end_of_test();
	end
	initial
	begin
		{lock_req, odd_second_req, copro_cont_req, bus_hold_req} = 4'h0;
		{copro_operand_req, exec_req, exec_req_soon, fetch_req} = 4'h0;
		{irq_ack_req, op_write, halt_instruction, multi_exception} = 4'h0;
		{nmi, maskable_irq, copro_overrun, slow_pick, stop, blk} = 6'h00;
		irq_enabled = 1'b1;
		void'($urandom(96));
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("reset", {ov, st[4:0], addr_oe_n, lock_n, st[6:5]}, 16'h01C4);
		@(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
			trial(7'h01 << i, 1'b0);
		trial(7'h01, 1'b1);
		trial(7'h7F, 1'b0);
		repeat (40)
			trial(7'($urandom), 1'($urandom));
		@(posedge clk);
		{exec_req, op_write} <= 2'h3;
		for (k = 0; k < 8 && grant_exec !== 1'b1; k++)
			@(negedge clk);
		@(posedge clk);
		{exec_req, bus_hold_req} <= 2'h1;
		for (k = 0; k < 20 && grant_exec !== 1'b0; k++)
			@(negedge clk);
		check("write idle", bus_hold_ack, 1'b0);
		@(negedge clk);
		check("write hold", bus_hold_ack, 1'b1);
		@(posedge clk);
		{bus_hold_req, irq_ack_req} <= 2'h1;
		for (k = 0; k < 30 && irq_ack_cycle !== 1'b1; k++)
			@(negedge clk);
		@(posedge clk);
		{irq_ack_req, bus_hold_req} <= 2'h1;
		{n_h, n_f, n_l, n_g, n_d} = '0;
		for (k = 0; k < 80 && irq_ack_cycle !== 1'b0; k++)
		begin
			@(negedge clk);
			n_h += (irq_ack_cycle && bus_hold_ack);
			n_f += (irq_ack_second && addr_oe_n);
			n_l += (irq_ack_cycle && !lock_n);
			n_g += (irq_ack_cycle && ov == 7'h00);
			n_d += (irq_ack_cycle && ov != 7'h00 && bus_status_1_n
				&& bus_status_0_n && lat !== 2'h0);
		end
		check("ack end", irq_ack_cycle, 1'b0);
		check("ack gap", 16'(n_g), 16'h0003);
		check("ack decode", n_d == 0, 1'b1);
		check("ack hold", n_h == 0, 1'b1);
		check("ack float", n_f != 0, 1'b1);
		check("ack lock", n_l != 0, 1'b1);
		for (k = 0; k < 8 && bus_hold_ack !== 1'b1; k++)
			@(negedge clk);
		check("hold after ack", bus_hold_ack, 1'b1);
		@(posedge clk);
		bus_hold_req <= 1'b0;
		repeat (3) @(negedge clk);
		check("addr driven", addr_oe_n, 1'b0);
		ev(5'h10);
		check("halt", st, 7'h43);
		stop = 1'b1;
		trial(7'h0C, 1'b0);
		trial(7'h06, 1'b0);
		ev(5'h04);
		check("nmi exit", st[6:5], 2'h0);
		ev(5'h10);
		ev(5'h02);
		check("irq exit", st[6:5], 2'h0);
		ev(5'h10);
		ev(5'h01);
		check("overrun exit", st[6:5], 2'h0);
		ev(5'h08);
		check("shutdown", st, 7'h22);
		ev(5'h02);
		check("irq stays", st[6:5], 2'h1);
		ev(5'h01);
		blk = 1'b1;
		check("overrun stays", st[6:5], 2'h1);
		trial(7'h04, 1'b0);
		ev(5'h04);
		stop = 1'b0;
		check("nmi shut exit", st[6:5], 2'h0);
		end_of_test();
	end
endmodule
